// ===== src/msr_map.svh
// Command codes, byte counts, bit positions, reset values and timing counts
// Behaviour
// - Status byte read anytime, no command needed
// - Status bits: motoroff, bkpt, err, wrap, index, traj, cmderr, busy
// - Motor-off set on reset, error stop, manual stop
// - Start-motion clears motor-off unless manual stop
// - Breakpoint exceeded sets breakpoint flag
// - Position error over threshold sets error flag
// - Position overflow sets wraparound flag
// - Armed index pulse sets flag, captures position
// - Trajectory complete is motor-off OR on-target
// - Read/write direction mismatch sets command error
// - Flags latch regardless of mask until cleared
// - Busy discards writes, reads return port buffer
// - Signals readback code 0C, two bytes, MSB first
// - Signals low byte mirrors status; bit0 armed index
// - Unmasked condition raises irq and signals bit15
// - Bit14 accel loaded, bit13 filter update pending
// - Direction and velocity mode change at start-motion
// - On-target set at trajectory end, cleared by start
// - Bit9 turn-off-on-error, bit8 byte output mode
// - Index and setpoint readbacks four bytes MSB first
// - Trajectory buffers move to working at start-motion
`ifndef MSR_MAP_SVH
`define MSR_MAP_SVH

// Command codes
`define MSR_CMD_START_MOTION     8'h01
`define MSR_CMD_RD_SETPOINT_POS  8'h08
`define MSR_CMD_RD_INDEX_POS     8'h09
`define MSR_CMD_RD_SIGNALS       8'h0C
`define MSR_CMD_LOAD_TRAJECTORY  8'h1F
`define MSR_CMD_CLEAR_IRQ_FLAGS  8'h1D
`define MSR_CMD_ARM_INDEX        8'h03
`define MSR_CMD_ERR_LIMIT_STOP   8'h1B
`define MSR_CMD_ERR_LIMIT_IRQ    8'h1A
`define MSR_CMD_BKPT_ABSOLUTE    8'h20
`define MSR_CMD_BKPT_RELATIVE    8'h21
`define MSR_CMD_UPDATE_FILTER    8'h04
`define MSR_CMD_BYTE_OUTPUT      8'h05
`define MSR_CMD_WIDE_OUTPUT      8'h06

// Byte counts per command
`define MSR_LEN_SIGNALS          4'h2
`define MSR_LEN_POSITION         4'h4
`define MSR_LEN_CTRL_WORD        4'h2
`define MSR_LEN_ERR_LIMIT        4'h2
`define MSR_LEN_BKPT             4'h4

// Trajectory control word bit positions
`define MSR_TC_FORWARD           12
`define MSR_TC_VEL_MODE          11
`define MSR_TC_MOTOR_OFF         8
`define MSR_TC_LOAD_ACCEL        5
`define MSR_TC_LOAD_VEL          3
`define MSR_TC_LOAD_POS          1

// Reset values
`define MSR_RST_MOTOR_OFF        1'b1
`define MSR_RST_BYTE_MODE        1'b1
`define MSR_RST_PIN_IDLE         1'b1

// Busy time after each accepted access
`define MSR_CLK_MHZ              250
`define MSR_BUSY_NS              100
`define MSR_BUSY_CYC             8'((`MSR_BUSY_NS * `MSR_CLK_MHZ + 999) / 1000)

`endif

// ===== src/msr_pkg.sv
// Types shared by the motion status reporting block
package msr_pkg;

  // Host bus pins, all active low except data
  typedef struct packed {
    logic       cs_n;
    logic       port_select_n;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] data;
  } msr_host_pins_t;

  // Events from the motion core, same clock
  typedef struct packed {
    logic breakpoint_hit;
    logic error_exceeded;
    logic wraparound;
    logic traj_done;
    logic sample_tick;
  } msr_core_evt_t;

  // Trajectory parameter set
  typedef struct packed {
    logic [15:0] ctrl;
    logic [31:0] accel;
    logic [31:0] vel;
    logic [31:0] pos;
  } msr_traj_t;

  // Host transfer sequencer
  typedef enum logic [1:0] {
    MSR_SEQ_IDLE  = 2'b00,
    MSR_SEQ_READ  = 2'b01,
    MSR_SEQ_WRITE = 2'b10
  } msr_seq_t;

endpackage : msr_pkg

// ===== src/msr_pin_sync.sv
// Two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
module msr_pin_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // First stage read only by the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= INIT;
      sync_out <= INIT;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : msr_pin_sync

// ===== src/msr_flag_bank.sv
// Sticky interrupt flags with mask-gated host interrupt
`timescale 1ns/1ps
module msr_flag_bank (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [5:0] set_evt,
  input  wire logic       clear_all,
  input  wire logic [5:0] irq_mask,
  output logic      [5:0] flags,
  output logic            host_irq
);

  // Flags latch regardless of mask; set beats clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags <= 6'h00;
    end else begin
      flags <= (flags & {6{~clear_all}}) | set_evt;
    end
  end

  // Unmasked condition raises the interrupt pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_irq <= 1'b0;
    end else if (|(set_evt & irq_mask)) begin
      host_irq <= 1'b1;
    end else if (clear_all) begin
      host_irq <= 1'b0;
    end
  end

endmodule : msr_flag_bank

// ===== src/msr_status_port.sv
// Host port, status byte, signals word and position readbacks
`timescale 1ns/1ps
`include "msr_map.svh"
module msr_status_port (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire msr_pkg::msr_host_pins_t host_pins,
  input  wire logic                   index_pulse,
  input  wire msr_pkg::msr_core_evt_t core_evt,
  input  wire logic [5:0]             irq_mask,
  input  wire logic [31:0]            actual_pos,
  input  wire logic [31:0]            desired_pos,
  output logic      [7:0]             host_data_out,
  output logic                        host_data_oe,
  output logic                        host_irq,
  output logic                        motor_off,
  output logic                        turnoff_on_error,
  output logic                        byte_output_mode,
  output logic                        start_pulse,
  output msr_pkg::msr_traj_t          traj_work,
  output logic      [31:0]            index_pos
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edges
  msr_pkg::msr_host_pins_t pins_q;
  msr_pkg::msr_host_pins_t pins_d_reg;
  logic                    index_q;
  logic                    index_d_reg;

  msr_pin_sync #(.WIDTH(12), .INIT(12'hFFF)) u_host_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (host_pins),
    .sync_out (pins_q)
  );

  msr_pin_sync #(.WIDTH(1), .INIT(1'b0)) u_index_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (index_pulse),
    .sync_out (index_q)
  );

  // Delayed copies for strobe edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins_d_reg  <= 12'hFFF;
      index_d_reg <= 1'b0;
    end else begin
      pins_d_reg  <= pins_q;
      index_d_reg <= index_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State declarations
  msr_pkg::msr_seq_t  seq_reg;
  logic [3:0]         left_reg;
  logic [31:0]        shift_reg;
  logic [7:0]         cmd_reg;
  logic               hdr_reg;
  logic [2:0]         pend_reg;
  logic [7:0]         busy_cnt_reg;
  msr_pkg::msr_traj_t prim_reg;
  logic               on_target_reg;
  logic               accel_loaded_reg;
  logic               udf_reg;
  logic               forward_reg;
  logic               vel_mode_reg;
  logic               armed_reg;
  logic               traj_lvl_d_reg;
  logic [5:0]         flags;
  logic [7:0]         status_byte;
  logic [15:0]        signals_word;

  ////////////////////////////////////////////////////////////////////////////
  // Host access decode
  logic       busy;
  logic       rd_start;
  logic       rd_end;
  logic       wr_end;
  logic       cmd_ok;
  logic       dwr_ok;
  logic       drd_ok;
  logic [7:0] wdata;
  logic [31:0] word_in;
  logic       hdr_done;
  logic       param_done;
  logic       cmd_err;
  logic       stt_cmd;
  logic       stt_ok;
  logic       accel_wr;
  logic       idx_evt;
  logic       traj_lvl;

  // Strobe edges qualified by chip select
  always_comb begin
    busy     = |busy_cnt_reg;
    rd_start = ~pins_q.cs_n & ~pins_q.rd_n & pins_d_reg.rd_n;
    rd_end   = ~pins_d_reg.cs_n & pins_q.rd_n & ~pins_d_reg.rd_n;
    wr_end   = ~pins_d_reg.cs_n & pins_q.wr_n & ~pins_d_reg.wr_n;
    wdata    = pins_d_reg.data;
    word_in  = {shift_reg[23:0], wdata};
    cmd_ok   = wr_end & ~pins_d_reg.port_select_n & ~busy;
    dwr_ok   = wr_end & pins_d_reg.port_select_n & ~busy;
    drd_ok   = rd_end & pins_d_reg.port_select_n & ~busy;
  end

  // Data phase decode and command checks
  always_comb begin
    hdr_done   = dwr_ok & (seq_reg == msr_pkg::MSR_SEQ_WRITE) & hdr_reg &
                 (cmd_reg == `MSR_CMD_LOAD_TRAJECTORY) & (left_reg == 4'h1);
    param_done = dwr_ok & (seq_reg == msr_pkg::MSR_SEQ_WRITE) & ~hdr_reg &
                 (cmd_reg == `MSR_CMD_LOAD_TRAJECTORY) & (left_reg[1:0] == 2'b01);
    accel_wr   = param_done & pend_reg[2];
    stt_cmd    = cmd_ok & (wdata == `MSR_CMD_START_MOTION);
    // Start refused while new acceleration waits on a running move
    stt_ok     = stt_cmd & ~(accel_loaded_reg & ~on_target_reg & ~motor_off);
    cmd_err    = (dwr_ok & (seq_reg != msr_pkg::MSR_SEQ_WRITE)) |
                 (drd_ok & (seq_reg != msr_pkg::MSR_SEQ_READ)) |
                 (stt_cmd & ~stt_ok);
    idx_evt    = armed_reg & index_q & ~index_d_reg;
    traj_lvl   = motor_off | on_target_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Busy timer after each accepted access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_cnt_reg <= 8'h00;
    end else if (cmd_ok | dwr_ok | drd_ok) begin
      busy_cnt_reg <= `MSR_BUSY_CYC;
    end else if (busy) begin
      busy_cnt_reg <= busy_cnt_reg - 8'h01;
    end
  end

  // Command and byte sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_reg   <= msr_pkg::MSR_SEQ_IDLE;
      left_reg  <= 4'h0;
      shift_reg <= 32'h0000_0000;
      cmd_reg   <= 8'h00;
      hdr_reg   <= 1'b0;
      pend_reg  <= 3'b000;
    end else if (cmd_ok) begin
      // A new command aborts any sequence in progress
      cmd_reg <= wdata;
      hdr_reg <= 1'b0;
      case (wdata)
        `MSR_CMD_RD_SIGNALS: begin
          seq_reg   <= msr_pkg::MSR_SEQ_READ;
          left_reg  <= `MSR_LEN_SIGNALS;
          shift_reg <= {signals_word, 16'h0000};
        end
        `MSR_CMD_RD_INDEX_POS: begin
          seq_reg   <= msr_pkg::MSR_SEQ_READ;
          left_reg  <= `MSR_LEN_POSITION;
          shift_reg <= index_pos;
        end
        `MSR_CMD_RD_SETPOINT_POS: begin
          seq_reg   <= msr_pkg::MSR_SEQ_READ;
          left_reg  <= `MSR_LEN_POSITION;
          shift_reg <= desired_pos;
        end
        `MSR_CMD_LOAD_TRAJECTORY: begin
          seq_reg  <= msr_pkg::MSR_SEQ_WRITE;
          left_reg <= `MSR_LEN_CTRL_WORD;
          hdr_reg  <= 1'b1;
        end
        `MSR_CMD_ERR_LIMIT_STOP, `MSR_CMD_ERR_LIMIT_IRQ: begin
          seq_reg  <= msr_pkg::MSR_SEQ_WRITE;
          left_reg <= `MSR_LEN_ERR_LIMIT;
        end
        `MSR_CMD_BKPT_ABSOLUTE, `MSR_CMD_BKPT_RELATIVE: begin
          seq_reg  <= msr_pkg::MSR_SEQ_WRITE;
          left_reg <= `MSR_LEN_BKPT;
        end
        default: begin
          seq_reg  <= msr_pkg::MSR_SEQ_IDLE;
          left_reg <= 4'h0;
        end
      endcase
    end else if (drd_ok & (seq_reg == msr_pkg::MSR_SEQ_READ)) begin
      // Most significant byte leaves first
      shift_reg <= {shift_reg[23:0], 8'h00};
      left_reg  <= left_reg - 4'h1;
      if (left_reg == 4'h1) begin
        seq_reg <= msr_pkg::MSR_SEQ_IDLE;
      end
    end else if (dwr_ok & (seq_reg == msr_pkg::MSR_SEQ_WRITE)) begin
      shift_reg <= word_in;
      if (hdr_done) begin
        // Control word tells how many parameter bytes follow
        hdr_reg  <= 1'b0;
        pend_reg <= {word_in[`MSR_TC_LOAD_ACCEL], word_in[`MSR_TC_LOAD_VEL],
                     word_in[`MSR_TC_LOAD_POS]};
        left_reg <= {2'b00, 2'(word_in[`MSR_TC_LOAD_ACCEL]) +
                     2'(word_in[`MSR_TC_LOAD_VEL]) + 2'(word_in[`MSR_TC_LOAD_POS])} << 2;
        if (word_in[`MSR_TC_LOAD_ACCEL:`MSR_TC_LOAD_POS] == 5'h00 ||
            {word_in[`MSR_TC_LOAD_ACCEL], word_in[`MSR_TC_LOAD_VEL],
             word_in[`MSR_TC_LOAD_POS]} == 3'b000) begin
          seq_reg <= msr_pkg::MSR_SEQ_IDLE;
        end
      end else begin
        left_reg <= left_reg - 4'h1;
        if (param_done) begin
          // Parameters arrive accel, then velocity, then position
          if (pend_reg[2]) begin
            pend_reg[2] <= 1'b0;
          end else if (pend_reg[1]) begin
            pend_reg[1] <= 1'b0;
          end else begin
            pend_reg[0] <= 1'b0;
          end
        end
        if (left_reg == 4'h1) begin
          seq_reg <= msr_pkg::MSR_SEQ_IDLE;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Primary buffers and working set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prim_reg <= '0;
    end else if (hdr_done) begin
      prim_reg.ctrl <= word_in[15:0];
    end else if (param_done) begin
      if (pend_reg[2]) begin
        prim_reg.accel <= word_in;
      end else if (pend_reg[1]) begin
        prim_reg.vel <= word_in;
      end else begin
        prim_reg.pos <= word_in;
      end
    end
  end

  // Working registers load only on start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      traj_work   <= '0;
      start_pulse <= 1'b0;
    end else begin
      start_pulse <= stt_ok;
      if (stt_ok) begin
        traj_work <= prim_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Motor-off flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      motor_off <= `MSR_RST_MOTOR_OFF;
    end else if (core_evt.error_exceeded & turnoff_on_error) begin
      motor_off <= 1'b1;
    end else if (stt_ok) begin
      motor_off <= prim_reg.ctrl[`MSR_TC_MOTOR_OFF];
    end
  end

  // Signals word mode and motion bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      on_target_reg    <= 1'b0;
      accel_loaded_reg <= 1'b0;
      udf_reg          <= 1'b0;
      forward_reg      <= 1'b0;
      vel_mode_reg     <= 1'b0;
    end else begin
      on_target_reg    <= core_evt.traj_done | (on_target_reg & ~stt_ok);
      accel_loaded_reg <= accel_wr | (accel_loaded_reg & ~stt_ok);
      udf_reg          <= (cmd_ok & (wdata == `MSR_CMD_UPDATE_FILTER)) |
                          (udf_reg & ~core_evt.sample_tick);
      if (stt_ok) begin
        forward_reg  <= prim_reg.ctrl[`MSR_TC_FORWARD];
        vel_mode_reg <= prim_reg.ctrl[`MSR_TC_VEL_MODE];
      end
    end
  end

  // Output mode and error response settings
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      turnoff_on_error <= 1'b0;
      byte_output_mode <= `MSR_RST_BYTE_MODE;
    end else if (cmd_ok) begin
      if (wdata == `MSR_CMD_ERR_LIMIT_STOP) turnoff_on_error <= 1'b1;
      if (wdata == `MSR_CMD_ERR_LIMIT_IRQ) turnoff_on_error <= 1'b0;
      if (wdata == `MSR_CMD_BYTE_OUTPUT) byte_output_mode <= 1'b1;
      if (wdata == `MSR_CMD_WIDE_OUTPUT) byte_output_mode <= 1'b0;
    end
  end

  // Index arming and capture
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_reg <= 1'b0;
      index_pos <= 32'h0000_0000;
    end else begin
      if (cmd_ok & (wdata == `MSR_CMD_ARM_INDEX)) begin
        armed_reg <= 1'b1;
      end else if (idx_evt) begin
        armed_reg <= 1'b0;
      end
      if (idx_evt) begin
        index_pos <= actual_pos;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags and host interrupt
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      traj_lvl_d_reg <= 1'b1;
    end else begin
      traj_lvl_d_reg <= traj_lvl;
    end
  end

  msr_flag_bank u_flags (
    .clk       (clk),
    .rst       (rst),
    .set_evt   ({core_evt.breakpoint_hit, core_evt.error_exceeded, core_evt.wraparound,
                 idx_evt, traj_lvl & ~traj_lvl_d_reg, cmd_err}),
    .clear_all (cmd_ok & (wdata == `MSR_CMD_CLEAR_IRQ_FLAGS)),
    .irq_mask  (irq_mask),
    .flags     (flags),
    .host_irq  (host_irq)
  );

  // Status byte and signals word
  always_comb begin
    status_byte  = {motor_off, flags, busy};
    signals_word = {host_irq, accel_loaded_reg, udf_reg, forward_reg, vel_mode_reg,
                    on_target_reg, turnoff_on_error, byte_output_mode,
                    status_byte[7:1], armed_reg};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data driver
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_data_out <= 8'h00;
      host_data_oe  <= 1'b0;
    end else begin
      host_data_oe <= ~pins_q.cs_n & ~pins_q.rd_n;
      if (rd_start) begin
        // Status read needs no command; data reads show the port buffer
        host_data_out <= pins_q.port_select_n ? shift_reg[31:24] : status_byte;
      end
    end
  end

endmodule : msr_status_port

// ===== test/msr_host_model.sv
// Host processor model on the asynchronous byte-wide port
`timescale 1ns/1ps
module msr_host_model (
  input  wire logic              clk,
  input  wire logic [7:0]        host_data_out,
  input  wire logic              host_data_oe,
  output msr_pkg::msr_host_pins_t host_pins
);
  logic       cs_n;
  logic       sel_data;
  logic       rd_n;
  logic       wr_n;
  logic       drv_en;
  logic [7:0] drv_data;
  logic [7:0] last;
  logic [7:0] bus;

  // Idle levels; a released bus shows the inverse of its last value
  initial begin
    cs_n = 1'b1; sel_data = 1'b1; rd_n = 1'b1; wr_n = 1'b1;
    drv_en = 1'b0; drv_data = 8'h00; last = 8'h00;
  end
  assign bus = host_data_oe ? host_data_out : (drv_en ? drv_data : ~last);
  assign host_pins = {cs_n, sel_data, rd_n, wr_n, bus};
  always @(posedge clk) last <= bus;

  // One strobe cycle, held until the answer is sampled
  task automatic xfer(input logic sel, input logic rd, input logic [7:0] wd,
                      output logic [7:0] rdv);
    @(negedge clk);
    cs_n = 1'b0; sel_data = sel; drv_data = wd; drv_en = !rd;
    if (rd) rd_n = 1'b0;
    else wr_n = 1'b0;
    repeat (5) @(posedge clk);
    rdv = host_data_out;
    @(negedge clk);
    rd_n = 1'b1; wr_n = 1'b1;
    repeat (4) @(negedge clk);
    cs_n = 1'b1; drv_en = 1'b0;
  endtask : xfer

  // Polls busy low before the access
  task automatic go(input logic sel, input logic rd, input logic [7:0] wd,
                    output logic [7:0] rdv);
    logic [7:0] s;
    int         n;
    s = 8'h01;
    n = 0;
    while (s[0] !== 1'b0 && n < 20) begin
      xfer(1'b0, 1'b1, 8'h00, s);
      n++;
    end
    xfer(sel, rd, wd, rdv);
  endtask : go
endmodule : msr_host_model

// ===== test/msr_status_port_assertions.sv
// Checker of the status port outputs against its inputs
`timescale 1ns/1ps
module msr_status_port_checker (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire msr_pkg::msr_host_pins_t host_pins,
  input wire logic                    index_pulse,
  input wire msr_pkg::msr_core_evt_t  core_evt,
  input wire logic [5:0]              irq_mask,
  input wire logic [7:0]              host_data_out,
  input wire logic                    host_data_oe,
  input wire logic                    host_irq,
  input wire logic                    motor_off,
  input wire logic                    turnoff_on_error,
  input wire logic                    byte_output_mode,
  input wire logic                    start_pulse,
  input wire msr_pkg::msr_traj_t      traj_work,
  input wire logic [31:0]             index_pos
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Output state and read path timing
  reset_state_a: assert property ($fell(rst) |-> motor_off && byte_output_mode && !host_irq)
    else $error("reset state wrong");
  read_drive_a: assert property ((!host_pins.cs_n && !host_pins.rd_n) [*4] |-> host_data_oe)
    else $error("read data not driven");
  read_release_a: assert property ((host_pins.cs_n || host_pins.rd_n) [*4] |-> !host_data_oe)
    else $error("read data not released");
  read_hold_a: assert property (host_data_oe && $past(host_data_oe) |-> $stable(host_data_out))
    else $error("read byte changed mid read");
  // Events and start handling
  irq_mask_a: assert property ($rose(host_irq) |-> $past(irq_mask) != 6'h00)
    else $error("interrupt with all masked");
  traj_load_a: assert property ($changed(traj_work) |-> ##[0:1] (start_pulse || $past(start_pulse, 2)))
    else $error("working set moved without start");
  motor_on_a: assert property ($fell(motor_off) |-> ##[0:1] (start_pulse || $past(start_pulse, 2)))
    else $error("motor on without start");
  error_stop_a: assert property (core_evt.error_exceeded && turnoff_on_error |-> ##[0:2] motor_off)
    else $error("error stop missed");
  index_grab_a: assert property ($changed(index_pos) |-> $past(index_pulse, 3) || $past(index_pulse, 4))
    else $error("index position moved without pulse");

  // Main scenarios reached
  cover property (start_pulse);
  cover property ($rose(host_irq));
  cover property ($changed(index_pos));
endmodule : msr_status_port_checker

bind msr_status_port msr_status_port_checker i_chk (
  .clk(clk), .rst(rst), .host_pins(host_pins), .index_pulse(index_pulse),
  .core_evt(core_evt), .irq_mask(irq_mask), .host_data_out(host_data_out),
  .host_data_oe(host_data_oe), .host_irq(host_irq), .motor_off(motor_off),
  .turnoff_on_error(turnoff_on_error), .byte_output_mode(byte_output_mode),
  .start_pulse(start_pulse), .traj_work(traj_work), .index_pos(index_pos)
);

// ===== test/msr_status_port_bench.sv
// Directed bench for the status port through its host bus
`timescale 1ns/1ps
`include "msr_map.svh"
module msr_status_port_bench;
  logic                    clk;
  logic                    rst;
  msr_pkg::msr_host_pins_t host_pins;
  logic                    index_pulse;
  msr_pkg::msr_core_evt_t  core_evt;
  logic [5:0]              irq_mask;
  logic [31:0]             actual_pos;
  logic [31:0]             desired_pos;
  logic [7:0]              host_data_out;
  logic                    host_data_oe;
  logic                    host_irq;
  logic                    motor_off;
  logic                    turnoff_on_error;
  logic                    byte_output_mode;
  logic                    start_pulse;
  msr_pkg::msr_traj_t      traj_work;
  logic [31:0]             index_pos;
  logic [7:0]              s;
  logic [7:0]              junk;
  logic [31:0]             v;
  int                      n_mismatch;
  int                      n_checks;
  int                      cycles;

  msr_host_model i_host (.clk(clk), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .host_pins(host_pins));
  msr_status_port i_dut (.clk(clk), .rst(rst), .host_pins(host_pins),
    .index_pulse(index_pulse), .core_evt(core_evt), .irq_mask(irq_mask),
    .actual_pos(actual_pos), .desired_pos(desired_pos), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .host_irq(host_irq), .motor_off(motor_off),
    .turnoff_on_error(turnoff_on_error), .byte_output_mode(byte_output_mode),
    .start_pulse(start_pulse), .traj_work(traj_work), .index_pos(index_pos));

  // Clock and cycle ceiling
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic stat(output logic [7:0] b);
    i_host.xfer(1'b0, 1'b1, 8'h00, b);
  endtask : stat
  task automatic cmd(input logic [7:0] c);
    i_host.go(1'b0, 1'b0, c, junk);
  endtask : cmd
  task automatic wr(input logic [7:0] b);
    i_host.go(1'b1, 1'b0, b, junk);
  endtask : wr
  // Command first, then bytes most significant first
  task automatic rdn(input logic [7:0] c, input int n, output logic [31:0] r);
    logic [7:0] b;
    cmd(c);
    r = 32'h0000_0000;
    for (int i = 0; i < n; i++) begin
      i_host.go(1'b1, 1'b1, 8'h00, b);
      r = {r[23:0], b};
    end
  endtask : rdn
  task automatic pulse(input logic [4:0] e);
    @(negedge clk);
    core_evt = msr_pkg::msr_core_evt_t'(e);
    @(negedge clk);
    core_evt = msr_pkg::msr_core_evt_t'(5'h00);
    repeat (2) @(negedge clk);
  endtask : pulse
  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  // Main sequence
  initial begin
    rst = 1'b1; index_pulse = 1'b0; irq_mask = 6'h01;
    core_evt = msr_pkg::msr_core_evt_t'(5'h00);
    actual_pos = 32'h1234_5678; desired_pos = 32'h8765_4321;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    stat(s); chk(s & 8'hFB, 8'h80);
    rdn(`MSR_CMD_RD_SIGNALS, 2, v); chk(v & 32'hFFFB, 32'h0180);
    cmd(`MSR_CMD_WIDE_OUTPUT); chk(byte_output_mode, 32'h0);
    cmd(`MSR_CMD_BYTE_OUTPUT); chk(byte_output_mode, 32'h1);
    done("reset");
    cmd(`MSR_CMD_LOAD_TRAJECTORY); wr(8'h18); wr(8'h22);
    for (int i = 0; i < 4; i++) wr(8'h01 >> (8 * (i ^ 1)));
    for (int i = 0; i < 4; i++) wr(i == 2 ? 8'h40 : 8'h00);
    rdn(`MSR_CMD_RD_SIGNALS, 2, v); chk(v[15:8], 32'h41);
    cmd(`MSR_CMD_START_MOTION); chk(motor_off, 32'h0);
    chk(traj_work.ctrl, 32'h1822); chk(traj_work.accel, 32'h0001_0000);
    chk(traj_work.pos, 32'h0000_4000); chk(traj_work.vel, 32'h0);
    rdn(`MSR_CMD_RD_SIGNALS, 2, v); chk(v[15:7], 32'h32);
    pulse(5'h02); stat(s); chk(s[2], 32'h1);
    done("trajectory");
    pulse(5'h14); stat(s); chk({s[6], s[4]}, 32'h3);
    chk(host_irq, 32'h0);
    cmd(`MSR_CMD_ERR_LIMIT_STOP); wr(8'h00); wr(8'h10); chk(turnoff_on_error, 32'h1);
    pulse(5'h08); stat(s); chk({s[7], s[5]}, 32'h3);
    cmd(`MSR_CMD_ERR_LIMIT_IRQ); wr(8'h00); wr(8'h10); chk(turnoff_on_error, 32'h0);
    i_host.go(1'b1, 1'b1, 8'h00, junk);
    stat(s); chk(s[1], 32'h1);
    chk(host_irq, 32'h1);
    rdn(`MSR_CMD_RD_SIGNALS, 2, v); chk(v[15], 32'h1);
    cmd(`MSR_CMD_CLEAR_IRQ_FLAGS); stat(s); chk(s[6:1], 32'h0);
    chk(host_irq, 32'h0);
    done("flags");
    cmd(`MSR_CMD_UPDATE_FILTER); stat(s); chk(s[0], 32'h1);
    i_host.xfer(1'b1, 1'b0, 8'hA5, junk);
    i_host.go(1'b0, 1'b1, 8'h00, s); chk(s[1], 32'h0);
    rdn(`MSR_CMD_RD_SIGNALS, 2, v); chk(v[13], 32'h1);
    pulse(5'h01);
    rdn(`MSR_CMD_RD_SIGNALS, 2, v); chk(v[13], 32'h0);
    done("busy");
    cmd(`MSR_CMD_ARM_INDEX);
    rdn(`MSR_CMD_RD_SIGNALS, 2, v); chk(v[0], 32'h1);
    @(negedge clk);
    index_pulse = 1'b1;
    repeat (8) @(negedge clk);
    index_pulse = 1'b0;
    stat(s); chk(s[3], 32'h1);
    chk(index_pos, 32'h1234_5678);
    rdn(`MSR_CMD_RD_INDEX_POS, 4, v); chk(v, 32'h1234_5678);
    rdn(`MSR_CMD_RD_SIGNALS, 2, v); chk(v[0], 32'h0);
    rdn(`MSR_CMD_RD_SETPOINT_POS, 4, v); chk(v, 32'h8765_4321);
    done("index");
    cmd(`MSR_CMD_LOAD_TRAJECTORY); wr(8'h00); wr(8'h00);
    cmd(`MSR_CMD_START_MOTION); chk(motor_off, 32'h0);
    cmd(`MSR_CMD_LOAD_TRAJECTORY); wr(8'h00); wr(8'h20);
    for (int i = 0; i < 4; i++) wr(i == 1 ? 8'h02 : 8'h00);
    cmd(`MSR_CMD_START_MOTION); stat(s); chk(s[1], 32'h1);
    chk(traj_work.accel, 32'h0001_0000); chk(motor_off, 32'h0);
    cmd(`MSR_CMD_LOAD_TRAJECTORY); wr(8'h01); wr(8'h00);
    pulse(5'h02); cmd(`MSR_CMD_START_MOTION); chk(motor_off, 32'h1);
    chk(traj_work.accel, 32'h0002_0000);
    done("start");
    conclude();
  end
endmodule : msr_status_port_bench
